//--- cis_clk_ctrl.sv
// start/stop sequencing of one clock source with its run and state report
// assumes start/stop are one-cycle pulses and osc_ready is a level synchronous to aclk
`timescale 1ns/1ns
module cis_clk_ctrl (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // tasks in, status out
    input  wire cis_pkg::cis_clk_task_s clk_task,
    output cis_pkg::cis_clk_stat_s      stat
);

    cis_pkg::cis_clk_state_e state;
    cis_pkg::cis_clk_state_e next_state;
    cis_pkg::cis_clk_stat_s  next_stat;

    always_comb begin
        next_state        = state;
        next_stat         = stat;
        next_stat.started = 1'b0;
        case (state)
            cis_pkg::st_stopped: begin
                if (clk_task.start) begin
                    next_state = cis_pkg::st_starting;
                end
            end
            cis_pkg::st_starting: begin
                if (clk_task.osc_ready) begin
                    next_state        = cis_pkg::st_running;
                    next_stat.started = 1'b1;
                end
            end
            cis_pkg::st_running: begin
            end
            default: begin
                next_state = cis_pkg::st_stopped;
            end
        endcase
        if (clk_task.start) begin
            next_stat.run_status = 1'b1;
            next_stat.src_req    = clk_task.src_sel;
        end
        // stop wins over a start in the same cycle
        if (clk_task.stop) begin
            next_state           = cis_pkg::st_stopped;
            next_stat.run_status = 1'b0;
            next_stat.started    = 1'b0;
        end
        next_stat.running = (next_state == cis_pkg::st_running);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= cis_pkg::st_stopped;
            stat  <= '0;
        end else begin
            state <= next_state;
            stat  <= next_stat;
        end
    end

endmodule : cis_clk_ctrl

//--- cis_clock_irq.sv
// top of the clock interrupt and status block: AXI4-Lite slave, two clock sequencers, two event bits
// assumes tasks and oscillator feedback are synchronous to aclk; event clears come from the event_clear input, not from a register
`timescale 1ns/1ns
`include "cis_regs.svh"
module cis_clock_irq (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [`CIS_ADDR_W-1:0]        awaddr,
    // axi4-lite write data
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    // axi4-lite write response
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    // axi4-lite read
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [`CIS_ADDR_W-1:0]        araddr,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    // clock tasks and oscillator feedback
    input  wire cis_pkg::cis_clk_task_s        fast_task,
    input  wire cis_pkg::cis_clk_task_s        slow_task,
    input  wire logic [1:0]                    event_clear,
    // events and interrupt
    output logic                               fast_clock_started_event,
    output logic                               slow_clock_started_event,
    output logic                               irq_request
);

    cis_pkg::cis_clk_stat_s   fast_stat;
    cis_pkg::cis_clk_stat_s   slow_stat;
    cis_pkg::cis_clk_task_s   fast_req;
    logic [1:0]               ev_pulse;
    logic [1:0]               ev_flag;
    logic [1:0]               en;
    logic [1:0]               pend;
    logic [1:0]               en_set;
    logic [1:0]               en_clear;

    // write path state
    logic                     aw_held;
    logic [`CIS_ADDR_W-1:0]   aw_addr_q;
    logic                     w_held;
    logic [31:0]              w_data_q;
    logic [3:0]               w_strb_q;
    logic                     next_aw_held;
    logic [`CIS_ADDR_W-1:0]   next_aw_addr_q;
    logic                     next_w_held;
    logic [31:0]              next_w_data_q;
    logic [3:0]               next_w_strb_q;
    logic                     next_awready;
    logic                     next_wready;
    logic                     next_bvalid;
    logic [1:0]               next_bresp;
    logic                     aw_ok;
    logic                     w_ok;
    logic                     do_write;
    logic [`CIS_ADDR_W-1:0]   wr_addr;
    logic [31:0]              wr_data;
    logic [3:0]               wr_strb;

    // read path state
    logic                     next_arready;
    logic                     next_rvalid;
    logic [31:0]              next_rdata;
    logic [1:0]               next_rresp;
    logic                     next_irq;

    // the fast clock always asks for the crystal source
    always_comb begin
        fast_req         = fast_task;
        fast_req.src_sel = `CIS_SRC_CRYSTAL;
    end

    cis_clk_ctrl u_fast (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clk_task (fast_req),
        .stat     (fast_stat)
    );

    cis_clk_ctrl u_slow (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clk_task (slow_task),
        .stat     (slow_stat)
    );

    assign ev_pulse[`CIS_BIT_FAST] = fast_stat.started;
    assign ev_pulse[`CIS_BIT_SLOW] = slow_stat.started;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_irq
            cis_irq_bit u_bit (
                .aclk         (aclk),
                .aresetn      (aresetn),
                .event_pulse  (ev_pulse[gi]),
                .event_clear  (event_clear[gi]),
                .enable_set   (en_set[gi]),
                .enable_clear (en_clear[gi]),
                .event_flag   (ev_flag[gi]),
                .enable       (en[gi]),
                .pending      (pend[gi])
            );
        end
    endgenerate

    assign fast_clock_started_event = ev_flag[`CIS_BIT_FAST];
    assign slow_clock_started_event = ev_flag[`CIS_BIT_SLOW];

    // write path: address and data are taken in either order, then one response
    always_comb begin
        aw_ok          = aw_held | (awvalid & awready);
        w_ok           = w_held | (wvalid & wready);
        wr_addr        = aw_held ? aw_addr_q : awaddr;
        wr_data        = w_held ? w_data_q : wdata;
        wr_strb        = w_held ? w_strb_q : wstrb;
        do_write       = aw_ok & w_ok & ~bvalid;
        next_aw_held   = aw_ok & ~do_write;
        next_aw_addr_q = wr_addr;
        next_w_held    = w_ok & ~do_write;
        next_w_data_q  = wr_data;
        next_w_strb_q  = wr_strb;
        next_bvalid    = bvalid & ~bready;
        next_bresp     = bresp;
        en_set         = 2'h0;
        en_clear       = 2'h0;
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp  = `CIS_RESP_OKAY;
            case (wr_addr)
                `CIS_OFF_EN_SET: begin
                    en_set = wr_strb[0] ? wr_data[1:0] : 2'h0;
                end
                `CIS_OFF_EN_CLEAR: begin
                    en_clear = wr_strb[0] ? wr_data[1:0] : 2'h0;
                end
                // status registers are read only; writes are accepted and dropped
                `CIS_OFF_PENDING, `CIS_OFF_FAST_RUN, `CIS_OFF_FAST_STAT,
                `CIS_OFF_SLOW_RUN, `CIS_OFF_SLOW_STAT: begin
                end
                default: begin
                    next_bresp = `CIS_RESP_SLVERR;
                end
            endcase
        end
        // no new address or data while a response waits
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready  = ~next_w_held & ~next_bvalid;
    end

    // read path: one read at a time, data sampled at the address handshake
    always_comb begin
        next_rvalid  = rvalid & ~rready;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (arvalid & arready) begin
            next_rvalid = 1'b1;
            next_rdata  = `CIS_RESET_WORD;
            next_rresp  = `CIS_RESP_OKAY;
            case (araddr)
                `CIS_OFF_EN_SET, `CIS_OFF_EN_CLEAR: begin
                    next_rdata[1:0] = en;
                end
                `CIS_OFF_PENDING: begin
                    next_rdata[`CIS_BIT_FAST] = pend[`CIS_BIT_FAST];
                    next_rdata[`CIS_BIT_SLOW] = pend[`CIS_BIT_SLOW];
                end
                `CIS_OFF_FAST_RUN: begin
                    next_rdata[`CIS_BIT_RUN] = fast_stat.run_status;
                end
                `CIS_OFF_FAST_STAT: begin
                    next_rdata[`CIS_BIT_SRC]   = fast_stat.running;
                    next_rdata[`CIS_BIT_STATE] = fast_stat.running;
                end
                `CIS_OFF_SLOW_RUN: begin
                    next_rdata[`CIS_BIT_RUN] = slow_stat.run_status;
                end
                `CIS_OFF_SLOW_STAT: begin
                    next_rdata[`CIS_BIT_SRC+1:`CIS_BIT_SRC] = slow_stat.src_req;
                    next_rdata[`CIS_BIT_STATE]              = slow_stat.running;
                end
                default: begin
                    next_rresp = `CIS_RESP_SLVERR;
                end
            endcase
        end
        next_arready = ~next_rvalid;
        next_irq     = |pend;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held     <= 1'b0;
            aw_addr_q   <= '0;
            w_held      <= 1'b0;
            w_data_q    <= `CIS_RESET_WORD;
            w_strb_q    <= 4'h0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= `CIS_RESP_OKAY;
            arready     <= 1'b0;
            rvalid      <= 1'b0;
            rdata       <= `CIS_RESET_WORD;
            rresp       <= `CIS_RESP_OKAY;
            irq_request <= 1'b0;
        end else begin
            aw_held     <= next_aw_held;
            aw_addr_q   <= next_aw_addr_q;
            w_held      <= next_w_held;
            w_data_q    <= next_w_data_q;
            w_strb_q    <= next_w_strb_q;
            awready     <= next_awready;
            wready      <= next_wready;
            bvalid      <= next_bvalid;
            bresp       <= next_bresp;
            arready     <= next_arready;
            rvalid      <= next_rvalid;
            rdata       <= next_rdata;
            rresp       <= next_rresp;
            irq_request <= next_irq;
        end
    end

    chk_enable_set_one:
    assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wr_addr == `CIS_OFF_EN_SET && wr_strb[0] && wr_data[0] |=> en[0])
    else $error("enable set write did not enable fast interrupt");

    chk_enable_set_zero:
    assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wr_addr == `CIS_OFF_EN_SET && !wr_data[1] |=> en[1] == $past(en[1]))
    else $error("writing zero to enable set changed the enable");

    chk_enable_clear:
    assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wr_addr == `CIS_OFF_EN_CLEAR && wr_strb[0] && wr_data[1] |=> !en[1])
    else $error("enable clear write did not disable slow interrupt");

    chk_enable_readback:
    assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == `CIS_OFF_EN_CLEAR |=> rvalid && rdata[1:0] == $past(en))
    else $error("enable readback wrong");

    chk_pending_read:
    assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == `CIS_OFF_PENDING |=> rdata == {30'h0, $past(pend)})
    else $error("pending readback wrong");

    chk_pending_def:
    assert property (@(posedge aclk) disable iff (!aresetn) pend == (ev_flag & en))
    else $error("pending differs from flag and enable");

    chk_irq_or:
    assert property (@(posedge aclk) disable iff (!aresetn)
        (pend != 2'h0) ##1 (pend != 2'h0) |-> irq_request)
    else $error("interrupt request missing while pending");

    chk_started_event:
    assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(fast_stat.running) |-> fast_stat.started ##1 fast_clock_started_event)
    else $error("fast clock running without started event");

    chk_stop_state:
    assert property (@(posedge aclk) disable iff (!aresetn)
        fast_task.stop |=> !fast_stat.running && !fast_stat.run_status)
    else $error("fast clock state not cleared by stop task");

    chk_fast_run:
    assert property (@(posedge aclk) disable iff (!aresetn)
        fast_task.start && !fast_task.stop |=> fast_stat.run_status)
    else $error("fast run status not set by start task");

    chk_slow_src:
    assert property (@(posedge aclk) disable iff (!aresetn)
        slow_task.start && !slow_task.stop |=> slow_stat.src_req == $past(slow_task.src_sel))
    else $error("slow requested source not captured");

    chk_fast_src_read:
    assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == `CIS_OFF_FAST_STAT |=> rdata[0] == $past(fast_stat.running))
    else $error("fast source field wrong");

    cov_fast_start: cover property (@(posedge aclk) disable iff (!aresetn)
        fast_task.start ##[1:20] fast_stat.running);
    cov_irq_raise: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_request));
    cov_pend_read: cover property (@(posedge aclk) disable iff (!aresetn)
        rvalid && rready && rdata[1:0] == 2'h3);

endmodule : cis_clock_irq

//--- cis_irq_bit.sv
// one started-event flag with its interrupt enable and pending bit
// assumes all inputs are one-cycle pulses synchronous to aclk
`timescale 1ns/1ns
module cis_irq_bit (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // event and enable control
    input  wire logic event_pulse,
    input  wire logic event_clear,
    input  wire logic enable_set,
    input  wire logic enable_clear,
    // state
    output logic      event_flag,
    output logic      enable,
    output logic      pending
);

    logic next_event_flag;
    logic next_enable;
    logic next_pending;

    always_comb begin
        // a new event outranks a clear in the same cycle
        next_event_flag = event_pulse | (event_flag & ~event_clear);
        next_enable     = enable_set | (enable & ~enable_clear);
        next_pending    = next_event_flag & next_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_flag <= 1'b0;
            enable     <= 1'b0;
            pending    <= 1'b0;
        end else begin
            event_flag <= next_event_flag;
            enable     <= next_enable;
            pending    <= next_pending;
        end
    end

endmodule : cis_irq_bit

//--- cis_pkg.sv
// types shared by the clock interrupt and status block
// assumes cis_regs.svh supplies all numeric constants
package cis_pkg;

    typedef enum logic [1:0] {
        st_stopped  = 2'b00,
        st_starting = 2'b01,
        st_running  = 2'b10
    } cis_clk_state_e;

    // task triggers and oscillator feedback for one clock
    typedef struct packed {
        logic       start;
        logic       stop;
        logic       osc_ready;
        logic [1:0] src_sel;
    } cis_clk_task_s;

    // run and status report of one clock
    typedef struct packed {
        logic       run_status;
        logic       running;
        logic [1:0] src_req;
        logic       started;
    } cis_clk_stat_s;

endpackage : cis_pkg

//--- cis_regs.svh
// register map, field positions and reset values of the clock interrupt and status block
// assumes byte addresses on a 32-bit register bus, one aligned word per register
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH

`define CIS_ADDR_W         12
`define CIS_OFF_EN_SET     12'h304
`define CIS_OFF_EN_CLEAR   12'h308
`define CIS_OFF_PENDING    12'h30C
`define CIS_OFF_FAST_RUN   12'h408
`define CIS_OFF_FAST_STAT  12'h40C
`define CIS_OFF_SLOW_RUN   12'h414
`define CIS_OFF_SLOW_STAT  12'h418

`define CIS_BIT_FAST       0
`define CIS_BIT_SLOW       1
`define CIS_BIT_RUN        0
`define CIS_BIT_SRC        0
`define CIS_BIT_STATE      16

`define CIS_RESET_WORD     32'h00000000
`define CIS_RESP_OKAY      2'h0
`define CIS_RESP_SLVERR    2'h2
`define CIS_SRC_CRYSTAL    2'h1

`endif

//--- tb_clock_irq_and_status.sv
// self-checking bench for the clock interrupt and status block
// assumes cis_regs.svh and cis_pkg are compiled first; the bench alone drives every input
`timescale 1ns/1ns
`include "cis_regs.svh"
module tb_clock_irq_and_status;
    logic                   aclk;
    logic                   aresetn;
    logic                   awvalid;
    logic                   awready;
    logic [11:0]            awaddr;
    logic                   wvalid;
    logic                   wready;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic                   bready;
    logic [1:0]             bresp;
    logic                   arvalid;
    logic                   arready;
    logic [11:0]            araddr;
    logic                   rvalid;
    logic                   rready;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    cis_pkg::cis_clk_task_s fast_task;
    cis_pkg::cis_clk_task_s slow_task;
    logic [1:0]             event_clear;
    logic                   fast_ev;
    logic                   slow_ev;
    logic                   irq_request;
    int                     failures;
    int                     comparisons;

    cis_clock_irq u_cis_clock_irq (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .fast_task(fast_task),
        .slow_task(slow_task), .event_clear(event_clear), .fast_clock_started_event(fast_ev),
        .slow_clock_started_event(slow_ev), .irq_request(irq_request));

    always #50 aclk = ~aclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    // address and data offered together, each released at its own handshake edge
    // bready and rready stay high between transfers so no edge sees them toggled twice
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        int   n;
        logic aw_done;
        logic w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done) && n < 50) begin
            @(posedge aclk);
            n++;
            aw_done = aw_done | (awvalid & awready);
            w_done = w_done | (wvalid & wready);
            awvalid <= ~aw_done;
            wvalid <= ~w_done;
        end
        do begin
            @(posedge aclk);
            n++;
        end while (!bvalid && n < 100);
        chk(32'(bvalid), 32'h1, "write response");
        chk(32'(bresp), 32'(exp_resp), "bresp");
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!rvalid && n < 100);
        chk(32'(rvalid), 32'h1, "read response");
        chk(rdata, exp, "rdata");
        chk(32'(rresp), 32'(exp_resp), "rresp");
    endtask : rd

    task automatic t_reset_values;
        logic [11:0] offs [7];
        offs = '{`CIS_OFF_EN_SET, `CIS_OFF_EN_CLEAR, `CIS_OFF_PENDING, `CIS_OFF_FAST_RUN,
                 `CIS_OFF_FAST_STAT, `CIS_OFF_SLOW_RUN, `CIS_OFF_SLOW_STAT};
        foreach (offs[i]) rd(offs[i], `CIS_RESET_WORD, `CIS_RESP_OKAY);
    endtask : t_reset_values

    // zero bits must leave the other enable alone, in both registers
    task automatic t_enables;
        wr(`CIS_OFF_EN_SET, 32'h1, `CIS_RESP_OKAY);
        rd(`CIS_OFF_EN_SET, 32'h1, `CIS_RESP_OKAY);
        wr(`CIS_OFF_EN_SET, 32'h2, `CIS_RESP_OKAY);
        rd(`CIS_OFF_EN_CLEAR, 32'h3, `CIS_RESP_OKAY);
        wr(`CIS_OFF_EN_CLEAR, 32'h1, `CIS_RESP_OKAY);
        rd(`CIS_OFF_EN_SET, 32'h2, `CIS_RESP_OKAY);
        wr(`CIS_OFF_EN_CLEAR, 32'h2, `CIS_RESP_OKAY);
        rd(`CIS_OFF_EN_CLEAR, 32'h0, `CIS_RESP_OKAY);
    endtask : t_enables

    task automatic t_fast_clock;
        wr(`CIS_OFF_EN_SET, 32'h3, `CIS_RESP_OKAY);
        fast_task.start <= 1'b1;
        tick(1);
        fast_task.start <= 1'b0;
        rd(`CIS_OFF_FAST_RUN, 32'h1, `CIS_RESP_OKAY);
        rd(`CIS_OFF_FAST_STAT, 32'h0, `CIS_RESP_OKAY);
        chk(32'(fast_ev), 32'h0, "fast event before oscillator");
        fast_task.osc_ready <= 1'b1;
        // running and the started pulse one edge after osc_ready, the flag one edge later
        tick(3);
        chk(32'(fast_ev), 32'h1, "fast event");
        tick(1);
        chk(32'(irq_request), 32'h1, "irq after fast start");
        rd(`CIS_OFF_FAST_STAT, 32'h00010001, `CIS_RESP_OKAY);
        rd(`CIS_OFF_PENDING, 32'h1, `CIS_RESP_OKAY);
        wr(`CIS_OFF_EN_CLEAR, 32'h1, `CIS_RESP_OKAY);
        rd(`CIS_OFF_PENDING, 32'h0, `CIS_RESP_OKAY);
        chk(32'(irq_request), 32'h0, "irq masked");
        wr(`CIS_OFF_EN_SET, 32'h1, `CIS_RESP_OKAY);
        fast_task.stop <= 1'b1;
        fast_task.osc_ready <= 1'b0;
        tick(1);
        fast_task.stop <= 1'b0;
        rd(`CIS_OFF_FAST_STAT, 32'h0, `CIS_RESP_OKAY);
        rd(`CIS_OFF_FAST_RUN, 32'h0, `CIS_RESP_OKAY);
        rd(`CIS_OFF_PENDING, 32'h1, `CIS_RESP_OKAY);
        event_clear <= 2'b01;
        tick(1);
        event_clear <= 2'b00;
        rd(`CIS_OFF_PENDING, 32'h0, `CIS_RESP_OKAY);
    endtask : t_fast_clock

    task automatic t_slow_clock;
        slow_task.src_sel <= 2'h2;
        slow_task.start <= 1'b1;
        tick(1);
        slow_task.start <= 1'b0;
        rd(`CIS_OFF_SLOW_RUN, 32'h1, `CIS_RESP_OKAY);
        rd(`CIS_OFF_SLOW_STAT, 32'h2, `CIS_RESP_OKAY);
        slow_task.osc_ready <= 1'b1;
        tick(3);
        chk(32'(slow_ev), 32'h1, "slow event");
        tick(1);
        chk(32'(irq_request), 32'h1, "irq after slow start");
        rd(`CIS_OFF_SLOW_STAT, 32'h00010002, `CIS_RESP_OKAY);
        rd(`CIS_OFF_PENDING, 32'h2, `CIS_RESP_OKAY);
        event_clear <= 2'b10;
        slow_task.osc_ready <= 1'b0;
        tick(1);
        event_clear <= 2'b00;
        rd(`CIS_OFF_PENDING, 32'h0, `CIS_RESP_OKAY);
        slow_task.stop <= 1'b1;
        tick(1);
        slow_task.stop <= 1'b0;
        rd(`CIS_OFF_SLOW_RUN, 32'h0, `CIS_RESP_OKAY);
        rd(`CIS_OFF_SLOW_STAT, 32'h2, `CIS_RESP_OKAY);
    endtask : t_slow_clock

    // pending is read-only; holes in the map answer with an error
    task automatic t_bus_edges;
        rd(12'h300, 32'h0, `CIS_RESP_SLVERR);
        wr(`CIS_OFF_PENDING, 32'h3, `CIS_RESP_OKAY);
        rd(`CIS_OFF_PENDING, 32'h0, `CIS_RESP_OKAY);
        wr(12'h500, 32'h3, `CIS_RESP_SLVERR);
        rd(`CIS_OFF_EN_SET, 32'h3, `CIS_RESP_OKAY);
        // lane 0 strobe low makes an enable write a no-op
        wstrb <= 4'h0;
        wr(`CIS_OFF_EN_CLEAR, 32'h3, `CIS_RESP_OKAY);
        wstrb <= 4'hF;
        rd(`CIS_OFF_EN_SET, 32'h3, `CIS_RESP_OKAY);
    endtask : t_bus_edges

    // a reset in mid-run must drop enables and clock status again
    task automatic t_mid_reset;
        aresetn <= 1'b0;
        tick(2);
        aresetn <= 1'b1;
        tick(2);
        rd(`CIS_OFF_EN_SET, 32'h0, `CIS_RESP_OKAY);
        rd(`CIS_OFF_SLOW_STAT, 32'h0, `CIS_RESP_OKAY);
    endtask : t_mid_reset

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        fast_task = '0;
        slow_task = '0;
        event_clear = 2'b00;
        failures = 0;
        comparisons = 0;
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        t_reset_values();
        t_enables();
        t_fast_clock();
        t_slow_clock();
        t_bus_edges();
        t_mid_reset();
        stop_test();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #(5000 * 100);
        failures++;
        stop_test();
    end
endmodule : tb_clock_irq_and_status
